// file: hw/efs_pkg.sv
package efs_pkg;
	// ----------------------------------------
	// Frame field codes
	// ----------------------------------------
	localparam logic [2:0] PROTO_VER_V1 = 3'h1;
	localparam logic [3:0] KEY_IDX_PLAIN = 4'h0;
	localparam logic [3:0] KEY_IDX_ENC_MAX = 4'he;
	localparam logic [3:0] KEY_IDX_CHANGE = 4'hf;
	localparam int KEY_STORE_BITS = 256;
	localparam int KEY_USE_BITS = 128;
	localparam int E2E_SIG_BYTES = 4;
	localparam int TSTAMP_BYTES = 2;
	localparam int NAS_BYTES = 2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int SECOND_NS = 1000000000;
	localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// Register map (byte addresses) and reset values
	// ----------------------------------------
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_EPOCH = 8'h04;
	localparam logic [7:0] REG_DATA_CNT = 8'h08;
	localparam logic [7:0] REG_INST_CNT = 8'h0c;
	localparam logic [7:0] REG_DISCARD = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CFG_NETID_LSB = 0;
	localparam int CFG_KEY_LSB = 8;
	localparam int CFG_VER_LSB = 12;
	localparam logic [7:0] RST_NETID = 8'h00;
	localparam logic [3:0] RST_KEY = 4'h0;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MSG_DATA = 2'b00,
		MSG_PROBE = 2'b01,
		MSG_RESPONSE = 2'b10,
		MSG_OTHER = 2'b11
	} efs_msg_e;

	typedef enum logic [1:0] {
		KEY_NET_ACCESS = 2'b00,
		KEY_ENCRYPT = 2'b01,
		KEY_CHANGE = 2'b10
	} efs_keykind_e;

	typedef enum logic [3:0] {
		FLD_IDLE = 4'b0000,
		FLD_CTRL = 4'b0001,
		FLD_NETID = 4'b0010,
		FLD_CNT_HI = 4'b0011,
		FLD_CNT_LO = 4'b0100,
		FLD_APP = 4'b0101,
		FLD_PAYLOAD = 4'b0110,
		FLD_E2E = 4'b0111,
		FLD_TSTAMP = 4'b1000,
		FLD_NAS = 4'b1001
	} efs_fld_e;

	typedef struct packed {
		efs_msg_e kind;
		logic [7:0] appLayerId;
		logic [15:0] echoCounter;
		logic [7:0] payloadLen;
	} efs_txhdr_s;

	typedef struct packed {
		efs_keykind_e kind;
		logic [3:0] index;
	} efs_keysel_s;

	typedef struct packed {
		logic [7:0] controlByte;
		logic [7:0] networkId;
		logic isInstall;
		logic isKeyChangeCmd;
	} efs_rxhdr_s;
endpackage

// file: hw/efs_rx_check.sv
`timescale 1ns/100ps
module efs_rx_check (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rxValid,
	input wire efs_pkg::efs_rxhdr_s rxHdr,
	input wire logic [3:0] cfgKeyIndex,
	input wire logic [7:0] cfgNetworkId,
	output logic rxAccept_ff,
	output logic rxDiscard_ff
);
	// ----------------------------------------
	// Header checks on downlink frames
	// ----------------------------------------
	logic [2:0] rxVer;
	logic [3:0] rxKey;
	logic keyOk;
	logic netOk;
	logic verOk;
	logic pass;
	assign rxVer = rxHdr.controlByte[7:5];
	assign rxKey = rxHdr.controlByte[3:0];
	// Key must match, bar plain install frames and key-change commands
	assign keyOk = (rxKey == cfgKeyIndex) ||
		(rxHdr.isInstall && rxKey == efs_pkg::KEY_IDX_PLAIN) ||
		(rxHdr.isKeyChangeCmd && rxKey == efs_pkg::KEY_IDX_CHANGE);
	assign netOk = (rxHdr.networkId == cfgNetworkId);
	assign verOk = (rxVer == efs_pkg::PROTO_VER_V1);
	assign pass = keyOk && netOk && verOk;

	// One-cycle verdict pulses
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxAccept_ff <= 1'b0;
			rxDiscard_ff <= 1'b0;
		end else begin
			rxAccept_ff <= rxValid && pass;
			rxDiscard_ff <= rxValid && !pass;
		end
	end

	property p_key_discard;
		@(posedge clk) disable iff (sys_rst)
		rxValid && !rxHdr.isInstall && !rxHdr.isKeyChangeCmd && rxKey != cfgKeyIndex
			|=> rxDiscard_ff && !rxAccept_ff;
	endproperty
	a_key_discard: assert property (p_key_discard) else $error("key mismatch kept");

	property p_net_discard;
		@(posedge clk) disable iff (sys_rst)
		rxValid && rxHdr.networkId != cfgNetworkId |=> rxDiscard_ff;
	endproperty
	a_net_discard: assert property (p_net_discard) else $error("netid mismatch kept");

	property p_probe_pass;
		@(posedge clk) disable iff (sys_rst)
		rxValid && rxHdr.isInstall && rxKey == efs_pkg::KEY_IDX_PLAIN && netOk && verOk
			|=> rxAccept_ff;
	endproperty
	a_probe_pass: assert property (p_probe_pass) else $error("plain install dropped");
endmodule

// file: hw/efs_framer.sv
`timescale 1ns/100ps
module efs_framer #(
	parameter int SEC_CYCLES = efs_pkg::SEC_CYCLES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata_ff,
	output logic avs_waitrequest_ff,
	input wire logic txStart,
	input wire efs_pkg::efs_txhdr_s txHdr,
	input wire logic plValid,
	input wire logic [7:0] plByte,
	output logic plReady_ff,
	input wire logic e2eSigValid,
	input wire logic [31:0] e2eSig,
	input wire logic nasSigValid,
	input wire logic [15:0] nasSig,
	input wire logic [efs_pkg::KEY_STORE_BITS-1:0] keyWord,
	output efs_pkg::efs_keysel_s keySel_ff,
	output logic [efs_pkg::KEY_USE_BITS-1:0] macKey_ff,
	output logic [7:0] outByte_ff,
	output logic outValid_ff,
	output efs_pkg::efs_fld_e outField_ff,
	output logic outLast_ff,
	input wire logic outReady,
	output logic txBusy_ff,
	input wire logic rxValid,
	input wire efs_pkg::efs_rxhdr_s rxHdr,
	output logic rxAccept_ff,
	output logic rxDiscard_ff
);
	// ----------------------------------------
	// Configuration and state registers
	// ----------------------------------------
	logic [7:0] netId_ff;
	logic [3:0] cfgKey_ff;
	logic [2:0] cfgVer_ff;
	logic [31:0] epoch_ff;
	logic [31:0] secCnt_ff;
	logic [15:0] dataCnt_ff;
	logic [15:0] instCnt_ff;
	logic [15:0] discardCnt_ff;
	logic [15:0] frameCnt_ff;
	logic [7:0] app_ff;
	logic [7:0] payLeft_ff;
	logic [3:0] ctrlKey_ff;
	logic [1:0] sub_ff;
	logic [31:0] e2e_ff;
	efs_pkg::efs_fld_e st_ff;
	efs_pkg::efs_fld_e nxt_st;
	logic avReq;
	logic avWr;
	logic start;
	logic slotFree;
	logic plTake;
	logic emit;
	logic [7:0] nxt_byte;
	logic [31:0] rdMux;

	assign avReq = avs_read || avs_write;
	assign avWr = avs_write && !avs_waitrequest_ff;
	assign start = txStart && !txBusy_ff;
	assign slotFree = !outValid_ff || outReady;
	assign plTake = plValid && plReady_ff;

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// Read data mux; unmapped addresses read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (avs_address)
			efs_pkg::REG_CONFIG: rdMux = {17'h0, cfgVer_ff, cfgKey_ff, netId_ff};
			efs_pkg::REG_EPOCH: rdMux = epoch_ff;
			efs_pkg::REG_DATA_CNT: rdMux = {16'h0, dataCnt_ff};
			efs_pkg::REG_INST_CNT: rdMux = {16'h0, instCnt_ff};
			efs_pkg::REG_DISCARD: rdMux = {16'h0, discardCnt_ff};
			efs_pkg::REG_STATUS: rdMux = {31'h0, txBusy_ff};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	// One wait cycle, then one answer cycle per access
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_waitrequest_ff <= 1'b1;
			avs_readdata_ff <= 32'h0000_0000;
		end else begin
			avs_waitrequest_ff <= !(avReq && avs_waitrequest_ff);
			if (avReq && avs_waitrequest_ff) begin
				avs_readdata_ff <= rdMux;
			end
		end
	end

	// Config writes take effect on the answer edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			netId_ff <= efs_pkg::RST_NETID;
			cfgKey_ff <= efs_pkg::RST_KEY;
			cfgVer_ff <= efs_pkg::PROTO_VER_V1;
		end else if (avWr && avs_address == efs_pkg::REG_CONFIG) begin
			netId_ff <= avs_writedata[efs_pkg::CFG_NETID_LSB +: 8];
			cfgKey_ff <= avs_writedata[efs_pkg::CFG_KEY_LSB +: 4];
			cfgVer_ff <= avs_writedata[efs_pkg::CFG_VER_LSB +: 3];
		end
	end

	// Epoch seconds: software sets it, hardware ticks it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			epoch_ff <= 32'h0000_0000;
			secCnt_ff <= 32'h0000_0000;
		end else if (avWr && avs_address == efs_pkg::REG_EPOCH) begin
			epoch_ff <= avs_writedata;
			secCnt_ff <= 32'h0000_0000;
		end else if (secCnt_ff == 32'(SEC_CYCLES - 1)) begin
			epoch_ff <= epoch_ff + 32'h0000_0001;
			secCnt_ff <= 32'h0000_0000;
		end else begin
			secCnt_ff <= secCnt_ff + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Message counters
	// ----------------------------------------
	// Counter sent with the frame is picked at start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dataCnt_ff <= 16'h0000;
			instCnt_ff <= 16'h0000;
			frameCnt_ff <= 16'h0000;
		end else if (start) begin
			unique case (txHdr.kind)
				efs_pkg::MSG_DATA: begin
					frameCnt_ff <= dataCnt_ff;
					dataCnt_ff <= dataCnt_ff + 16'h0001;
				end
				efs_pkg::MSG_PROBE: begin
					frameCnt_ff <= instCnt_ff;
					instCnt_ff <= instCnt_ff + 16'h0001;
				end
				efs_pkg::MSG_RESPONSE: frameCnt_ff <= txHdr.echoCounter;
				efs_pkg::MSG_OTHER: frameCnt_ff <= txHdr.echoCounter;
			endcase
		end
	end

	// ----------------------------------------
	// Key selection for the signature engine
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			keySel_ff <= '{kind: efs_pkg::KEY_NET_ACCESS, index: efs_pkg::KEY_IDX_PLAIN};
			ctrlKey_ff <= efs_pkg::KEY_IDX_PLAIN;
			app_ff <= 8'h00;
		end else if (start) begin
			app_ff <= txHdr.appLayerId;
			if (txHdr.kind == efs_pkg::MSG_PROBE) begin
				keySel_ff <= '{kind: efs_pkg::KEY_NET_ACCESS, index: efs_pkg::KEY_IDX_PLAIN};
				ctrlKey_ff <= efs_pkg::KEY_IDX_PLAIN;
			end else if (cfgKey_ff == efs_pkg::KEY_IDX_PLAIN) begin
				keySel_ff <= '{kind: efs_pkg::KEY_NET_ACCESS, index: cfgKey_ff};
				ctrlKey_ff <= cfgKey_ff;
			end else if (cfgKey_ff == efs_pkg::KEY_IDX_CHANGE) begin
				keySel_ff <= '{kind: efs_pkg::KEY_CHANGE, index: cfgKey_ff};
				ctrlKey_ff <= cfgKey_ff;
			end else begin
				keySel_ff <= '{kind: efs_pkg::KEY_ENCRYPT, index: cfgKey_ff};
				ctrlKey_ff <= cfgKey_ff;
			end
		end
	end

	// Upper half of the stored key feeds the engines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			macKey_ff <= '0;
		end else begin
			macKey_ff <= keyWord[efs_pkg::KEY_STORE_BITS-1 -: efs_pkg::KEY_USE_BITS];
		end
	end

	// ----------------------------------------
	// Field sequencer
	// ----------------------------------------
	// Next byte and field; emit when a byte is loaded
	always_comb begin
		nxt_st = st_ff;
		nxt_byte = 8'h00;
		emit = 1'b0;
		unique case (st_ff)
			efs_pkg::FLD_IDLE: begin
				if (start) begin
					nxt_st = efs_pkg::FLD_CTRL;
				end
			end
			efs_pkg::FLD_CTRL: begin
				emit = slotFree;
				nxt_byte = {cfgVer_ff, 1'b0, ctrlKey_ff};
				nxt_st = emit ? efs_pkg::FLD_NETID : st_ff;
			end
			efs_pkg::FLD_NETID: begin
				emit = slotFree;
				nxt_byte = netId_ff;
				nxt_st = emit ? efs_pkg::FLD_CNT_HI : st_ff;
			end
			efs_pkg::FLD_CNT_HI: begin
				emit = slotFree;
				nxt_byte = frameCnt_ff[15:8];
				nxt_st = emit ? efs_pkg::FLD_CNT_LO : st_ff;
			end
			efs_pkg::FLD_CNT_LO: begin
				emit = slotFree;
				nxt_byte = frameCnt_ff[7:0];
				nxt_st = emit ? efs_pkg::FLD_APP : st_ff;
			end
			efs_pkg::FLD_APP: begin
				emit = slotFree;
				nxt_byte = app_ff;
				if (emit) begin
					nxt_st = (payLeft_ff == 8'h00) ? efs_pkg::FLD_E2E : efs_pkg::FLD_PAYLOAD;
				end
			end
			efs_pkg::FLD_PAYLOAD: begin
				emit = plTake;
				nxt_byte = plByte;
				if (plTake && payLeft_ff == 8'h01) begin
					nxt_st = efs_pkg::FLD_E2E;
				end
			end
			efs_pkg::FLD_E2E: begin
				emit = slotFree && e2eSigValid;
				nxt_byte = e2eSig[8*(3-sub_ff) +: 8];
				if (emit && sub_ff == 2'(efs_pkg::E2E_SIG_BYTES - 1)) begin
					nxt_st = efs_pkg::FLD_TSTAMP;
				end
			end
			efs_pkg::FLD_TSTAMP: begin
				emit = slotFree;
				nxt_byte = sub_ff[0] ? epoch_ff[7:0] : epoch_ff[15:8];
				if (emit && sub_ff == 2'(efs_pkg::TSTAMP_BYTES - 1)) begin
					nxt_st = efs_pkg::FLD_NAS;
				end
			end
			efs_pkg::FLD_NAS: begin
				emit = slotFree && nasSigValid;
				nxt_byte = sub_ff[0] ? nasSig[7:0] : nasSig[15:8];
				if (emit && sub_ff == 2'(efs_pkg::NAS_BYTES - 1)) begin
					nxt_st = efs_pkg::FLD_IDLE;
				end
			end
			default: nxt_st = efs_pkg::FLD_IDLE;
		endcase
	end

	// State, byte index within a multi-byte field, payload count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= efs_pkg::FLD_IDLE;
			sub_ff <= 2'h0;
			payLeft_ff <= 8'h00;
		end else begin
			st_ff <= nxt_st;
			if (start) begin
				payLeft_ff <= txHdr.payloadLen;
			end else if (plTake) begin
				payLeft_ff <= payLeft_ff - 8'h01;
			end
			if (nxt_st != st_ff) begin
				sub_ff <= 2'h0;
			end else if (emit) begin
				sub_ff <= sub_ff + 2'h1;
			end
		end
	end

	// Payload handshake: ready only when the output slot is sure to be empty next cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			plReady_ff <= 1'b0;
		end else begin
			plReady_ff <= (st_ff == efs_pkg::FLD_PAYLOAD) && !outValid_ff && !plTake;
		end
	end

	// Output byte register with back-pressure
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			outByte_ff <= 8'h00;
			outValid_ff <= 1'b0;
			outField_ff <= efs_pkg::FLD_IDLE;
			outLast_ff <= 1'b0;
		end else if (emit) begin
			outByte_ff <= nxt_byte;
			outValid_ff <= 1'b1;
			outField_ff <= st_ff;
			outLast_ff <= (st_ff == efs_pkg::FLD_NAS) && (nxt_st == efs_pkg::FLD_IDLE);
		end else if (outReady) begin
			outValid_ff <= 1'b0;
			outLast_ff <= 1'b0;
		end
	end

	// Busy from start to the last byte being taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txBusy_ff <= 1'b0;
		end else if (start) begin
			txBusy_ff <= 1'b1;
		end else if (outValid_ff && outReady && outLast_ff) begin
			txBusy_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Downlink header check
	// ----------------------------------------
	efs_rx_check u_rx_check (
		.clk(clk),
		.sys_rst(sys_rst),
		.rxValid(rxValid),
		.rxHdr(rxHdr),
		.cfgKeyIndex(cfgKey_ff),
		.cfgNetworkId(netId_ff),
		.rxAccept_ff(rxAccept_ff),
		.rxDiscard_ff(rxDiscard_ff)
	);

	// Discards counted for software, saturating
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			discardCnt_ff <= 16'h0000;
		end else if (rxDiscard_ff && discardCnt_ff != 16'hffff) begin
			discardCnt_ff <= discardCnt_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_bus_answer;
		!avs_waitrequest_ff ##1 avs_waitrequest_ff;
	endsequence
	property p_bus_answer;
		@(posedge clk) disable iff (sys_rst)
		avReq && avs_waitrequest_ff |=> s_bus_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

	property p_data_cnt;
		@(posedge clk) disable iff (sys_rst)
		start && txHdr.kind == efs_pkg::MSG_DATA |=>
			dataCnt_ff == $past(dataCnt_ff) + 16'h0001 && frameCnt_ff == $past(dataCnt_ff);
	endproperty
	a_data_cnt: assert property (p_data_cnt) else $error("data counter not stepped");

	property p_flow_apart;
		@(posedge clk) disable iff (sys_rst)
		start && txHdr.kind == efs_pkg::MSG_PROBE |=>
			$stable(dataCnt_ff) && instCnt_ff == $past(instCnt_ff) + 16'h0001;
	endproperty
	a_flow_apart: assert property (p_flow_apart) else $error("install flow touched data");

	property p_echo;
		@(posedge clk) disable iff (sys_rst)
		start && txHdr.kind == efs_pkg::MSG_RESPONSE |=>
			frameCnt_ff == $past(txHdr.echoCounter) && $stable(dataCnt_ff);
	endproperty
	a_echo: assert property (p_echo) else $error("response counter not echoed");

	property p_key_probe;
		@(posedge clk) disable iff (sys_rst)
		start && txHdr.kind == efs_pkg::MSG_PROBE |=> keySel_ff.kind == efs_pkg::KEY_NET_ACCESS;
	endproperty
	a_key_probe: assert property (p_key_probe) else $error("probe not on net key");

	property p_key_chg;
		@(posedge clk) disable iff (sys_rst)
		start && txHdr.kind != efs_pkg::MSG_PROBE && cfgKey_ff == efs_pkg::KEY_IDX_CHANGE
			|=> keySel_ff.kind == efs_pkg::KEY_CHANGE;
	endproperty
	a_key_chg: assert property (p_key_chg) else $error("index 15 not key-change");

	property p_ctrl_byte;
		@(posedge clk) disable iff (sys_rst)
		outValid_ff && outField_ff == efs_pkg::FLD_CTRL |->
			outByte_ff[4] == 1'b0 && outByte_ff[3:0] == ctrlKey_ff;
	endproperty
	a_ctrl_byte: assert property (p_ctrl_byte) else $error("control byte malformed");

	sequence s_cnt_lo;
		outValid_ff && outField_ff == efs_pkg::FLD_CNT_LO && outByte_ff == frameCnt_ff[7:0];
	endsequence
	property p_order;
		@(posedge clk) disable iff (sys_rst)
		outValid_ff && outReady && outField_ff == efs_pkg::FLD_CNT_HI |=> s_cnt_lo;
	endproperty
	a_order: assert property (p_order) else $error("counter low byte out of order");

	property p_key_half;
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> macKey_ff == $past(keyWord[255:128]);
	endproperty
	a_key_half: assert property (p_key_half) else $error("wrong key half used");
endmodule

// file: tb/efs_link_model.sv
`timescale 1ns/100ps
module efs_link_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] outByte,
	input wire logic outValid,
	input wire efs_pkg::efs_fld_e outField,
	input wire logic outLast,
	input wire logic txBusy,
	input wire logic slow,
	output logic outReady,
	output logic e2eSigValid,
	output logic [31:0] e2eSig,
	output logic nasSigValid,
	output logic [15:0] nasSig,
	output logic [255:0] keyWord
);
	// ----------------------------------------
	// Radio side sink and signature source
	// ----------------------------------------
	localparam logic [31:0] E2E_VAL = 32'hc1d2e3f4;
	localparam logic [15:0] NAS_VAL = 16'h9a7b;
	logic [12:0] got[$];
	logic [3:0] busyCnt;

	// Key store word; only the upper half may reach the signer
	initial keyWord = {128'h0123456789abcdef0f1e2d3c4b5a6978, 128'h55aa55aa55aa55aa55aa55aa55aa55aa};

	// Record accepted bytes, stall every other cycle in slow mode
	always @(posedge clk) begin
		if (outValid && outReady)
			got.push_back({outLast, outField, outByte});
		outReady <= sys_rst ? 1'b0 : (slow ? !outReady : 1'b1);
		if (sys_rst || !txBusy)
			busyCnt <= 4'h0;
		else if (busyCnt != 4'hf)
			busyCnt <= busyCnt + 4'h1;
	end

	// Signatures arrive late in a frame; withdrawn values show inverted
	always_comb begin
		e2eSigValid = busyCnt >= 4'h6;
		e2eSig = e2eSigValid ? E2E_VAL : ~E2E_VAL;
		nasSigValid = busyCnt >= 4'h9;
		nasSig = nasSigValid ? NAS_VAL : ~NAS_VAL;
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, txStart = 1'b0;
	logic plValid = 1'b0, rxValid = 1'b0, slow = 1'b0;
	logic [7:0] avs_address = 8'h00, plByte = 8'h00;
	logic [31:0] avs_writedata = 32'h0, rdata, avs_readdata_ff, e2eSig;
	efs_pkg::efs_txhdr_s txHdr = '0;
	efs_pkg::efs_rxhdr_s rxHdr = '0;
	logic avs_waitrequest_ff, plReady_ff, e2eSigValid, nasSigValid, outValid_ff, outLast_ff;
	logic outReady, txBusy_ff, rxAccept_ff, rxDiscard_ff;
	logic [15:0] nasSig;
	logic [255:0] keyWord;
	efs_pkg::efs_keysel_s keySel_ff;
	logic [127:0] macKey_ff;
	logic [7:0] outByte_ff;
	efs_pkg::efs_fld_e outField_ff;
	int fails = 0, nTests = 0;

	always #2 clk = ~clk;

	efs_framer #(.SEC_CYCLES(5000)) dut (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
		.avs_waitrequest_ff(avs_waitrequest_ff), .txStart(txStart), .txHdr(txHdr),
		.plValid(plValid), .plByte(plByte), .plReady_ff(plReady_ff),
		.e2eSigValid(e2eSigValid), .e2eSig(e2eSig), .nasSigValid(nasSigValid),
		.nasSig(nasSig), .keyWord(keyWord), .keySel_ff(keySel_ff), .macKey_ff(macKey_ff),
		.outByte_ff(outByte_ff), .outValid_ff(outValid_ff), .outField_ff(outField_ff),
		.outLast_ff(outLast_ff), .outReady(outReady), .txBusy_ff(txBusy_ff),
		.rxValid(rxValid), .rxHdr(rxHdr), .rxAccept_ff(rxAccept_ff),
		.rxDiscard_ff(rxDiscard_ff));

	efs_link_model snk (.clk(clk), .sys_rst(sys_rst), .outByte(outByte_ff),
		.outValid(outValid_ff), .outField(outField_ff), .outLast(outLast_ff),
		.txBusy(txBusy_ff), .slow(slow), .outReady(outReady), .e2eSigValid(e2eSigValid),
		.e2eSig(e2eSig), .nasSigValid(nasSigValid), .nasSig(nasSig), .keyWord(keyWord));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		begin
			nTests++;
			if (g !== e) begin
				$display("mismatch %s expected %h seen %h", nm, e, g);
				fails++;
			end
		end
	endtask

	// One Avalon access; waits for waitrequest low, read data lands in rdata
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		begin
			avs_address <= a;
			avs_write <= wr;
			avs_read <= !wr;
			avs_writedata <= d;
			do begin
				@(posedge clk);
			end while (avs_waitrequest_ff !== 1'b0);
			rdata = avs_readdata_ff;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk("register", {96'h0, e}, {96'h0, rdata});
		end
	endtask

	// Sends one frame with two payload bytes and checks every byte and tag
	task automatic frame(input efs_pkg::efs_msg_e k, input logic [15:0] cnt,
		input logic [3:0] key, input efs_pkg::efs_keykind_e kk);
		logic [12:0] exp [15];
		int n;
		begin
			exp = '{{5'h01, 3'h1, 1'b0, key}, {5'h02, 8'h5a}, {5'h03, cnt[15:8]},
				{5'h04, cnt[7:0]}, {5'h05, 8'h3c}, {5'h06, 8'ha0}, {5'h06, 8'ha1},
				{5'h07, 8'hc1}, {5'h07, 8'hd2}, {5'h07, 8'he3}, {5'h07, 8'hf4},
				{5'h08, 8'h23}, {5'h08, 8'h45}, {5'h09, 8'h9a}, {5'h19, 8'h7b}};
			snk.got.delete();
			txStart <= 1'b1;
			txHdr <= '{k, 8'h3c, (k == efs_pkg::MSG_DATA || k == efs_pkg::MSG_PROBE) ? ~cnt : cnt, 8'h02};
			// Start held a second edge: the busy framer must ignore the repeat
			repeat (2) @(posedge clk);
			txStart <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				plValid <= 1'b1;
				plByte <= 8'ha0 + 8'(i);
				n = 0;
				do begin
					@(posedge clk);
					n++;
				end while (plReady_ff !== 1'b1 && n < 100);
				if (n >= 100)
					fails++;
			end
			plValid <= 1'b0;
			chk("keySel", {122'h0, kk, key}, {122'h0, keySel_ff});
			chk("macKey", keyWord[255:128], macKey_ff);
			n = 0;
			while (txBusy_ff !== 1'b0 && n < 500) begin
				@(posedge clk);
				n++;
			end
			if (n >= 500)
				fails++;
			chk("frameLength", 128'd15, 128'(snk.got.size()));
			for (int i = 0; i < 15; i++)
				chk("frameByte", {115'h0, exp[i]}, {115'h0, snk.got[i]});
		end
	endtask

	task automatic rx(input logic [7:0] ctl, input logic [7:0] net, input logic inst,
		input logic kc, input logic acc);
		begin
			rxValid <= 1'b1;
			rxHdr <= '{ctl, net, inst, kc};
			@(posedge clk);
			rxValid <= 1'b0;
			@(posedge clk);
			chk("rxAccept", {127'h0, acc}, {127'h0, rxAccept_ff});
			chk("rxDiscard", {127'h0, !acc}, {127'h0, rxDiscard_ff});
		end
	endtask

	task automatic report_and_stop;
		begin
			if (fails == 0 && nTests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(efs_pkg::REG_CONFIG, 32'h00001000);
		rd(8'h20, 32'h0);
		bus(1'b1, efs_pkg::REG_DATA_CNT, 32'hffffffff);
		rd(efs_pkg::REG_DATA_CNT, 32'h0);
		bus(1'b1, efs_pkg::REG_CONFIG, 32'h0000135a);
		rd(efs_pkg::REG_CONFIG, 32'h0000135a);
		bus(1'b1, efs_pkg::REG_EPOCH, 32'h00012345);
		frame(efs_pkg::MSG_DATA, 16'h0000, 4'h3, efs_pkg::KEY_ENCRYPT);
		slow <= 1'b1;
		frame(efs_pkg::MSG_DATA, 16'h0001, 4'h3, efs_pkg::KEY_ENCRYPT);
		slow <= 1'b0;
		frame(efs_pkg::MSG_PROBE, 16'h0000, 4'h0, efs_pkg::KEY_NET_ACCESS);
		frame(efs_pkg::MSG_RESPONSE, 16'hbeef, 4'h3, efs_pkg::KEY_ENCRYPT);
		rd(efs_pkg::REG_DATA_CNT, 32'h2);
		rd(efs_pkg::REG_INST_CNT, 32'h1);
		rx(8'h23, 8'h5a, 1'b0, 1'b0, 1'b1);
		rx(8'h23, 8'h5b, 1'b0, 1'b0, 1'b0);
		rx(8'h24, 8'h5a, 1'b0, 1'b0, 1'b0);
		rx(8'h20, 8'h5a, 1'b1, 1'b0, 1'b1);
		rx(8'h20, 8'h5a, 1'b0, 1'b0, 1'b0);
		rx(8'h2f, 8'h5a, 1'b0, 1'b1, 1'b1);
		rx(8'h43, 8'h5a, 1'b0, 1'b0, 1'b0);
		rd(efs_pkg::REG_DISCARD, 32'h4);
		bus(1'b1, efs_pkg::REG_CONFIG, 32'h00001f5a);
		frame(efs_pkg::MSG_OTHER, 16'h1234, 4'hf, efs_pkg::KEY_CHANGE);
		bus(1'b1, efs_pkg::REG_CONFIG, 32'h0000105a);
		frame(efs_pkg::MSG_DATA, 16'h0002, 4'h0, efs_pkg::KEY_NET_ACCESS);
		rd(efs_pkg::REG_DATA_CNT, 32'h3);
		rd(efs_pkg::REG_STATUS, 32'h0);
		report_and_stop();
	end

	// Watchdog against a hung handshake
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule
